// ==== logic/cscs_regs.vh ====
// Purpose: Constants for the chip-select combine and E-clock stretch stage.
// Assumes: Included by bare name from every design file of this block.
// Notes: Offsets are byte addresses on the plain register port.
//
// Contract
// - With no routing bit set, each select pin follows only its own matched area.
// - Only gp2_drives_program: program pin adds general-2, general-2 pin silent, general-1 own.
// - With only gp1_drives_program set, program pin covers program or general-1 areas.
// - Both drive-program bits: program pin covers all three areas, neither general pin asserts.
// - Only gp1_drives_gp2: general-2 pin covers both generals, general-1 silent, program own.
// - Select outputs change in step with the driven E clock; bus_tick_out keeps the free-running divider rate.
// - E stays high for the programmed extra bus cycles only on hits of a stretching select.
// - During a stretch every other internal clock and tick keeps its normal rate.
// - Each two-bit stretch field is a binary count of extra cycles from none to three.
// - The 8-bit stretch register resets to zero; io, gp1, gp2, program in 7:6, 5:4, 3:2, 1:0.
// - With gp1_drives_gp2 set and gp2_drives_program clear, general-1 is ORed into general-2 and driven on its pin.
// - With gp2_drives_program set, general-2 is ORed into program and driven on its pin.

`ifndef CSCS_REGS_VH
`define CSCS_REGS_VH

// Register offsets
`define CSCS_ADDR_W 8
`define CSCS_OFF_STRETCH 8'h5a
`define CSCS_OFF_ROUTE 8'h5b
`define CSCS_OFF_STATUS 8'h5c

// Reset values
`define CSCS_STRETCH_RST 8'h00
`define CSCS_ROUTE_RST 3'h0

// Stretch field positions (low bit of each pair)
`define CSCS_FLD_IO 6
`define CSCS_FLD_GP1 4
`define CSCS_FLD_GP2 2
`define CSCS_FLD_PROG 0

// Routing bit positions
`define CSCS_RT_G2DP 0
`define CSCS_RT_G1DP 1
`define CSCS_RT_G1G2 2

// Status bit positions
`define CSCS_ST_E 0
`define CSCS_ST_STR 1
`define CSCS_ST_REM 2
`define CSCS_ST_PINS 4

// Timing: E half period in reference clocks (8 ns at 250 MHz)
`define CSCS_E_HALF_CYC 8'h02

`endif

// ==== logic/cscs_stretch.v ====
// Purpose: E-clock phase sequencer with zero to three stretched bus cycles.
// Assumes: mid and end pulses come from a free-running divider on the same clock.
// Notes: The divider never pauses, so only E itself is held during a stretch.
`timescale 1ns/10ps
`include "cscs_regs.vh"

module cscs_stretch (
  input wire ref_clk_in,
  input wire rst_in,
  input wire mid_in,
  input wire end_in,
  input wire [1:0] count_in,
  output wire cycle_start_out,
  output wire e_clk_out,
  output wire stretching_out,
  output wire [1:0] remain_out
);

  localparam [2:0] ST_LOW = 3'h1;
  localparam [2:0] ST_HIGH = 3'h2;
  localparam [2:0] ST_STR = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] rem_q;
  reg [1:0] rem_d;
  reg e_q;
  reg e_d;
  reg start_c;

  // Next phase; a stretch is whole bus periods of held-high E
  always @* begin
    state_d = state_q;
    rem_d = rem_q;
    e_d = e_q;
    start_c = 1'b0;
    case (state_q)
      ST_LOW: begin
        if (mid_in) begin
          state_d = ST_HIGH;
          e_d = 1'b1;
        end
      end
      ST_HIGH: begin
        if (end_in) begin
          if (count_in != 2'h0) begin
            state_d = ST_STR;
            rem_d = count_in;
          end else begin
            state_d = ST_LOW;
            e_d = 1'b0;
            start_c = 1'b1;
          end
        end
      end
      ST_STR: begin
        if (end_in) begin
          if (rem_q == 2'h1) begin
            state_d = ST_LOW;
            rem_d = 2'h0;
            e_d = 1'b0;
            start_c = 1'b1;
          end else begin
            rem_d = rem_q - 2'h1;
          end
        end
      end
      default: begin
        state_d = ST_LOW;
        rem_d = 2'h0;
        e_d = 1'b0;
      end
    endcase
  end

  // Phase registers
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_LOW;
      rem_q <= 2'h0;
      e_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rem_q <= rem_d;
      e_q <= e_d;
    end
  end

  assign cycle_start_out = start_c;
  assign e_clk_out = e_q;
  assign stretching_out = state_q[2];
  assign remain_out = rem_q;

endmodule // cscs_stretch

// ==== logic/cscs_top.v ====
// Purpose: Chip-select combine and E-clock stretch output stage.
// Assumes: Area hits come from an address decoder on ref_clk_in, one at a time.
// Notes: Pins are active high; polarity and decode live elsewhere.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "cscs_regs.vh"

module cscs_top #(
  parameter [7:0] E_HALF = `CSCS_E_HALF_CYC
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output wire [7:0] rd_data_out,
  input wire io_hit_in,
  input wire prog_hit_in,
  input wire gp1_hit_in,
  input wire gp2_hit_in,
  output wire e_clk_out,
  output wire cycle_start_out,
  output wire bus_tick_out,
  output wire io_select_pin_out,
  output wire program_select_pin_out,
  output wire general1_select_pin_out,
  output wire general2_select_pin_out
);

  localparam [7:0] LAST = (E_HALF * 8'h02) - 8'h01;
  localparam [7:0] MID = E_HALF - 8'h01;

  reg [7:0] stretch_q;
  reg [2:0] route_q;
  reg [7:0] rd_data_q;
  reg [7:0] phase_q;
  reg tick_q;
  reg [3:0] pins_q;
  reg [1:0] count_q;
  reg [1:0] count_d;
  reg [3:0] pins_d;
  reg [7:0] rd_mux;
  wire mid_p;
  wire end_p;
  wire start_p;
  wire e_clk;
  wire stretching;
  wire [1:0] remain;
  wire [3:0] hits;
  wire [1:0] fld [0:3];
  wire gp1_dg2;
  wire gp1_dp;
  wire gp2_dp;

  // Hit order: io, program, general-1, general-2
  assign hits = {io_hit_in, prog_hit_in, gp1_hit_in, gp2_hit_in};
  assign gp1_dg2 = route_q[`CSCS_RT_G1G2];
  assign gp1_dp = route_q[`CSCS_RT_G1DP];
  assign gp2_dp = route_q[`CSCS_RT_G2DP];

  // Stretch fields unpacked in register order: io, general-1, general-2, program
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_fld
      assign fld[gi] = stretch_q[2 * gi + 1:2 * gi];
    end
  endgenerate

  // Register writes; stretch and routing steer the bus stage
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stretch_q <= `CSCS_STRETCH_RST;
      route_q <= `CSCS_ROUTE_RST;
    end else if (wr_en_in) begin
      if (addr_in == `CSCS_OFF_STRETCH) begin
        stretch_q <= wr_data_in;
      end
      if (addr_in == `CSCS_OFF_ROUTE) begin
        route_q <= wr_data_in[2:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_mux = 8'h00;
    case (addr_in)
      `CSCS_OFF_STRETCH: rd_mux = stretch_q;
      `CSCS_OFF_ROUTE: rd_mux = {5'h00, route_q};
      `CSCS_OFF_STATUS: rd_mux = {pins_q, remain, stretching, e_clk};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_q <= 8'h00;
    end else if (rd_en_in) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  // Free-running bus divider; never held, so timers keep time
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= end_p;
      if (end_p) begin
        phase_q <= 8'h00;
      end else begin
        phase_q <= phase_q + 8'h01;
      end
    end
  end

  assign mid_p = (phase_q == MID);
  assign end_p = (phase_q == LAST);

  // Stretch count of the select that matched; none when nothing hit
  always @* begin
    count_d = 2'h0;
    if (hits[3]) begin
      count_d = fld[3];
    end else if (hits[2]) begin
      count_d = fld[0];
    end else if (hits[1]) begin
      count_d = fld[2];
    end else if (hits[0]) begin
      count_d = fld[1];
    end
  end

  // Pin combine; ranges assumed disjoint, overlap gives OR of both
  always @* begin
    pins_d = 4'h0;
    pins_d[3] = hits[3];
    // Program pin absorbs routed generals
    pins_d[2] = hits[2] | (gp1_dp & hits[1]) | (gp2_dp & hits[0]);
    // General-2 pin silenced when routed to program
    pins_d[0] = ~gp2_dp & (hits[0] | (gp1_dg2 & hits[1]));
    // General-1 pin silenced when it drives a live target
    pins_d[1] = hits[1] & ~gp1_dp & ~(gp1_dg2 & ~gp2_dp);
  end

  // Access latched at each bus cycle start, aligned to E falling edge
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_q <= 4'h0;
      count_q <= 2'h0;
    end else if (start_p) begin
      pins_q <= pins_d;
      count_q <= count_d;
    end
  end

  cscs_stretch u_stretch (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .mid_in(mid_p),
    .end_in(end_p),
    .count_in(count_q),
    .cycle_start_out(start_p),
    .e_clk_out(e_clk),
    .stretching_out(stretching),
    .remain_out(remain)
  );

  assign rd_data_out = rd_data_q;
  assign e_clk_out = e_clk;
  assign cycle_start_out = start_p;
  assign bus_tick_out = tick_q;
  assign io_select_pin_out = pins_q[3];
  assign program_select_pin_out = pins_q[2];
  assign general1_select_pin_out = pins_q[1];
  assign general2_select_pin_out = pins_q[0];

endmodule // cscs_top

// ==== dv/cscs_props.sv ====
// Purpose: Assertions on the select combine and E stretch stage.
// Assumes: Route and stretch shadows follow register port writes.
// Notes: Tick spacing assumes E_HALF of 2.
`timescale 1ns/10ps
module cscs_props #(
  parameter [7:0] E_HALF = 8'h02
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] rd_data_out,
  input wire io_hit_in,
  input wire prog_hit_in,
  input wire gp1_hit_in,
  input wire gp2_hit_in,
  input wire e_clk_out,
  input wire cycle_start_out,
  input wire bus_tick_out,
  input wire io_select_pin_out,
  input wire program_select_pin_out,
  input wire general1_select_pin_out,
  input wire general2_select_pin_out
);
  reg [7:0] st_q;
  reg [2:0] rt_q;
  reg [1:0] n_q;
  reg [7:0] hi_q;
  wire [3:0] h = {io_hit_in, prog_hit_in, gp1_hit_in, gp2_hit_in};
  wire [3:0] pin = {io_select_pin_out, program_select_pin_out,
    general1_select_pin_out, general2_select_pin_out};
  // Expected pins; io wins the count, then program, general 1, general 2
  wire [3:0] x = {h[3], h[2] | (rt_q[1] & h[1]) | (rt_q[0] & h[0]),
    h[1] & ~rt_q[1] & ~(rt_q[2] & ~rt_q[0]), ~rt_q[0] & (h[0] | (rt_q[2] & h[1]))};
  wire [1:0] n_d = h[3] ? st_q[7:6] : h[2] ? st_q[1:0] : h[1] ? st_q[5:4] :
    h[0] ? st_q[3:2] : 2'h0;
  // Shadows, latched count and E high length
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= 8'h00;
      rt_q <= 3'h0;
      n_q <= 2'h0;
      hi_q <= 8'h00;
    end else begin
      if (wr_en_in && addr_in == 8'h5a) st_q <= wr_data_in;
      if (wr_en_in && addr_in == 8'h5b) rt_q <= wr_data_in[2:0];
      if (cycle_start_out) n_q <= n_d;
      hi_q <= e_clk_out ? hi_q + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  chk_io_pin: assert property (cycle_start_out |=> pin[3] == $past(x[3]))
    else $error("io pin wrong");
  chk_prog_pin: assert property (cycle_start_out |=> pin[2] == $past(x[2]))
    else $error("program pin wrong");
  chk_gp1_pin: assert property (cycle_start_out |=> pin[1] == $past(x[1]))
    else $error("general1 pin wrong");
  chk_gp2_pin: assert property (cycle_start_out |=> pin[0] == $past(x[0]))
    else $error("general2 pin wrong");
  chk_pins_hold: assert property (!cycle_start_out |=> $stable(pin))
    else $error("pins moved mid cycle");
  chk_e_fall: assert property (cycle_start_out |=> $fell(e_clk_out))
    else $error("E did not fall");
  chk_e_stretch: assert property (
    cycle_start_out |-> hi_q + 8'h01 == E_HALF * (8'h01 + {5'h0, n_q, 1'b0}))
    else $error("E high length wrong");
  chk_tick_rate: assert property (bus_tick_out |=> !bus_tick_out [*3] ##1 bus_tick_out)
    else $error("tick rate wrong");
  chk_rd_stretch: assert property (rd_en_in && addr_in == 8'h5a |=> rd_data_out == st_q)
    else $error("stretch readback wrong");
endmodule // cscs_props

bind cscs_top cscs_props #(.E_HALF(E_HALF)) i_cscs_props (.*);

// ==== dv/cscs_mem_model.sv ====
// Purpose: External memory that logs each access it was selected for.
// Assumes: Select pins are valid from the E fall that opens an access.
// Notes: An access is reported at the E fall that closes it.
`timescale 1ns/10ps
module cscs_mem_model (
  input wire ref_clk_in,
  input wire rst_in,
  input wire e_clk_in,
  input wire [3:0] sel_in,
  output reg done_out,
  output reg [3:0] sel_out,
  output reg [7:0] hi_out
);
  reg e_q;
  reg [7:0] cnt_q;
  reg [3:0] sel_q;
  // Count E high clocks and report on each fall
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      e_q <= 1'b0;
      cnt_q <= 8'h00;
      sel_q <= 4'h0;
      done_out <= 1'b0;
      sel_out <= 4'h0;
      hi_out <= 8'h00;
    end else begin
      e_q <= e_clk_in;
      cnt_q <= e_clk_in ? cnt_q + 8'h01 : 8'h00;
      done_out <= e_q & ~e_clk_in;
      if (e_q & ~e_clk_in) begin
        sel_out <= sel_q;
        hi_out <= cnt_q;
        sel_q <= sel_in;
      end
    end
  end
endmodule // cscs_mem_model

// ==== dv/cscs_tb_top.sv ====
// Purpose: Bench for the select combine and E stretch stage.
// Assumes: Hits are one-hot or idle, ranges never overlap.
// Notes: Writes land just after a sampling edge, so they hit the next access.
`timescale 1ns/10ps
module cscs_tb_top;
  localparam [7:0] E_HALF = 8'h02;
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [7:0] addr_in = 8'h00;
  reg [7:0] wr_data_in = 8'h00;
  reg wr_en_in = 1'b0;
  reg rd_en_in = 1'b0;
  reg [3:0] hit = 4'h0;
  reg [7:0] st = 8'h00;
  reg [2:0] rt = 3'h0;
  reg rv = 1'b0;
  wire io_hit_in = hit[3];
  wire prog_hit_in = hit[2];
  wire gp1_hit_in = hit[1];
  wire gp2_hit_in = hit[0];
  wire [7:0] rd_data_out;
  wire e_clk_out, cycle_start_out, bus_tick_out, done;
  wire io_select_pin_out, program_select_pin_out;
  wire general1_select_pin_out, general2_select_pin_out;
  wire [3:0] sel;
  wire [7:0] hi;
  integer errors = 0;
  integer checked = 0;
  reg [11:0] aq[$];
  reg [7:0] rq[$];

  cscs_top #(.E_HALF(E_HALF)) i_cscs_top (.*);
  cscs_mem_model i_cscs_mem_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .e_clk_in(e_clk_out), .sel_in({io_select_pin_out, program_select_pin_out,
    general1_select_pin_out, general2_select_pin_out}), .done_out(done),
    .sel_out(sel), .hi_out(hi));

  initial forever #2 ref_clk_in = ~ref_clk_in;

  task automatic check(input [11:0] got, input [11:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Pins and E high length an access should produce
  function automatic [11:0] expect_of(input [3:0] h);
    reg [3:0] p;
    reg [1:0] n;
    p[3] = h[3];
    p[2] = h[2] | (rt[1] & h[1]) | (rt[0] & h[0]);
    p[1] = h[1] & ~rt[1] & ~(rt[2] & ~rt[0]);
    p[0] = ~rt[0] & (h[0] | (rt[2] & h[1]));
    n = h[3] ? st[7:6] : h[2] ? st[1:0] : h[1] ? st[5:4] : h[0] ? st[3:2] : 2'h0;
    expect_of = {p, E_HALF * (8'h01 + {5'h0, n, 1'b0})};
  endfunction

  // One access: note it, pick new hits, then a write and a read
  task automatic step(input [7:0] wa, input [7:0] wd, input [7:0] ra);
    do @(posedge ref_clk_in); while (cycle_start_out !== 1'b1);
    aq.push_back(expect_of(hit));
    hit <= 4'h1 << ($urandom % 5);
    wr_en_in <= (wa != 8'h00);
    addr_in <= wa;
    wr_data_in <= wd;
    if (wa == 8'h5a) st = wd;
    if (wa == 8'h5b) rt = wd[2:0];
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
    rd_en_in <= (ra != 8'h00);
    addr_in <= ra;
    if (ra != 8'h00) rq.push_back(ra == 8'h5a ? st : ra == 8'h5b ? {5'h0, rt} : 8'h00);
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
  endtask

  // Oldest note against each reported access or read
  always @(posedge ref_clk_in) begin
    rv <= rd_en_in;
    if (rv) check({4'h0, rd_data_out}, {4'h0, rq.pop_front()});
    if (done) check({sel, hi}, aq.pop_front());
  end

  initial begin
    void'($urandom(32'h2f56));
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    aq.push_back({4'h0, E_HALF});
    step(8'h00, 8'h00, 8'h5a);
    step(8'h00, 8'h00, 8'h40);
    for (int r = 0; r < 8; r++) begin
      step(8'h5b, {5'h0, r[2:0]}, 8'h5b);
      repeat (6) step(8'h5a, 8'($urandom), 8'h5a);
    end
    while (aq.size() != 0) @(posedge ref_clk_in);
    tally_and_finish;
  end

  // Hang guard, far beyond the expected run
  initial begin
    #80000;
    errors = errors + 1;
    tally_and_finish;
  end
endmodule // cscs_tb_top
